/* sadc_consts.svh */
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// apb byte addresses
`define SADC_ADDR_CTRL     12'h0d0
`define SADC_ADDR_RES_HI   12'h0d4
`define SADC_ADDR_RES_LO   12'h0d8
`define SADC_ADDR_IRQ_STAT 12'h0dc
`define SADC_ADDR_IRQ_MASK 12'h0e0
`define SADC_ADDR_PIN_EN   12'h0e4

// control register fields
`define SADC_CTRL_START    0
`define SADC_CTRL_DIV_LO   1
`define SADC_CTRL_DIV_HI   2
`define SADC_CTRL_EOC      3
`define SADC_CTRL_CH_LO    4
`define SADC_CTRL_CH_HI    5
`define SADC_CTRL_RESET    8'h00

// conversion timing
`define SADC_SETUP_CLKS    4'h0a
`define SADC_EDGES_PER_BIT 2'h3
`define SADC_NUM_BITS      4'h0a
`define SADC_SAR_INIT      10'h200
`define SADC_RES_BITS      10

// divider terminal counts, fxx/2 fxx/4 fxx/8 fxx/16
`define SADC_DIV2_TC       4'h1
`define SADC_DIV4_TC       4'h3
`define SADC_DIV8_TC       4'h7
`define SADC_DIV16_TC      4'hf

`endif

/* sadc_pkg.sv */
package sadc_pkg;
    typedef enum logic [1:0] {
        SADC_DIV2,
        SADC_DIV4,
        SADC_DIV8,
        SADC_DIV16
    } sadc_div_t;

    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SETUP,
        SADC_CONVERT,
        SADC_DONE
    } sadc_state_t;
endpackage : sadc_pkg

/* sadc_clk_div.sv */
`timescale 1ns/100ps
`include "sadc_consts.svh"

module sadc_clk_div (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire logic              run,
    input  wire sadc_pkg::sadc_div_t sel,
    output logic                   tick
);
    logic [3:0] cnt_q;
    logic [3:0] tc;

    always_comb begin
        case (sel)
            sadc_pkg::SADC_DIV2:  tc = `SADC_DIV2_TC;
            sadc_pkg::SADC_DIV4:  tc = `SADC_DIV4_TC;
            sadc_pkg::SADC_DIV8:  tc = `SADC_DIV8_TC;
            default:              tc = `SADC_DIV16_TC;
        endcase
    end

    // restart from zero on each conversion so setup length is exact
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 4'h0;
            tick  <= 1'b0;
        end else if (!run || cnt_q >= tc) begin
            cnt_q <= 4'h0;
            tick  <= run;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick  <= 1'b0;
        end
    end
endmodule : sadc_clk_div

/* sadc_sequencer.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_consts.svh"

// Summary of operation
// RL1 - two-bit field picks one of four inputs
// RL2 - writing start bit one begins conversion
// RL3 - approximation register loads half scale first
// RL4 - ten-bit result, one channel at once
// RL5 - end flag set after final bit
// RL6 - result copied out, then sequencer idles
// RL7 - next conversion overwrites result, unprotected
// RL8 - ten setup clocks, four per bit
// RL9 - conversion clock divided, bits two-one select
// RL10 - reset clears the start bit
// RL11 - software keeps conversion above minimum time
// RL12 - software avoids low power during conversion
// RL13 - control register read/write at fixed address
// RL14 - analog pin enable, others stay I/O
// RL15 - result split into high and low
// RL16 - start clears end flag until result
module sadc_sequencer (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_above,
    output logic      [9:0]  dac_code,
    output logic      [1:0]  mux_sel,
    output logic      [3:0]  analog_pin_en,
    output logic             conv_busy,
    output logic             irq
);
    sadc_pkg::sadc_state_t state_q;
    logic [7:0]  ctrl_q;
    logic [9:0]  sar_q;
    logic [9:0]  res_q;
    logic [3:0]  cnt_q;
    logic [1:0]  edge_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic [3:0]  pin_q;
    logic        cmp_s1_q;
    logic        cmp_s2_q;
    logic        tick;
    logic        wr;
    logic        rd;
    logic        start_wr;
    logic        done_ev;
    logic        hit;
    logic [31:0] rdata_d;
    logic [3:0]  bit_idx;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign start_wr = wr && paddr == `SADC_ADDR_CTRL
                      && pwdata[`SADC_CTRL_START];
    assign done_ev = state_q == sadc_pkg::SADC_DONE;
    assign bit_idx = cnt_q - 4'h1;

    sadc_clk_div u_div (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (state_q != sadc_pkg::SADC_IDLE),
        .sel      (sadc_pkg::sadc_div_t'(
                   ctrl_q[`SADC_CTRL_DIV_HI:`SADC_CTRL_DIV_LO])), // [RL9]
        .tick     (tick)
    );

    // comparator is asynchronous to the sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= cmp_above;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // control register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `SADC_CTRL_RESET; // [RL10]
        end else begin
            if (wr && paddr == `SADC_ADDR_CTRL) begin
                // channel and divider writable, eoc is hardware owned
                ctrl_q[`SADC_CTRL_CH_HI:`SADC_CTRL_CH_LO] <=
                    pwdata[`SADC_CTRL_CH_HI:`SADC_CTRL_CH_LO]; // [RL1]
                ctrl_q[`SADC_CTRL_DIV_HI:`SADC_CTRL_DIV_LO] <=
                    pwdata[`SADC_CTRL_DIV_HI:`SADC_CTRL_DIV_LO]; // [RL13]
                ctrl_q[`SADC_CTRL_START] <= pwdata[`SADC_CTRL_START];
            end
            if (start_wr) begin
                ctrl_q[`SADC_CTRL_EOC] <= 1'b0; // [RL16]
            end
            if (done_ev) begin
                // set wins over a coincident start write
                ctrl_q[`SADC_CTRL_EOC]   <= 1'b1; // [RL5]
                ctrl_q[`SADC_CTRL_START] <= 1'b0;
            end
        end
    end

    // sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= sadc_pkg::SADC_IDLE;
            sar_q   <= 10'h000;
            cnt_q   <= 4'h0;
            edge_q  <= 2'h0;
        end else begin
            case (state_q)
                sadc_pkg::SADC_IDLE: begin
                    if (ctrl_q[`SADC_CTRL_START]) begin // [RL2]
                        state_q <= sadc_pkg::SADC_SETUP;
                        sar_q   <= `SADC_SAR_INIT; // [RL3]
                        cnt_q   <= 4'h0;
                        edge_q  <= 2'h0;
                    end
                end
                sadc_pkg::SADC_SETUP: begin
                    if (tick) begin
                        if (cnt_q == `SADC_SETUP_CLKS - 4'h1) begin // [RL8]
                            state_q <= sadc_pkg::SADC_CONVERT;
                            cnt_q   <= `SADC_NUM_BITS;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                sadc_pkg::SADC_CONVERT: begin
                    if (tick) begin
                        if (edge_q == `SADC_EDGES_PER_BIT) begin // [RL8]
                            edge_q <= 2'h0;
                            // decide this bit, trial the next one
                            sar_q[bit_idx] <= cmp_s2_q; // [RL3] [RL4]
                            if (bit_idx != 4'h0) begin
                                sar_q[bit_idx - 4'h1] <= 1'b1;
                            end
                            cnt_q <= bit_idx;
                            if (bit_idx == 4'h0) begin
                                state_q <= sadc_pkg::SADC_DONE;
                            end
                        end else begin
                            edge_q <= edge_q + 2'h1;
                        end
                    end
                end
                sadc_pkg::SADC_DONE: begin
                    state_q <= sadc_pkg::SADC_IDLE; // [RL6]
                end
                default: begin
                    state_q <= sadc_pkg::SADC_IDLE;
                end
            endcase
        end
    end

    // result overwritten on every completion, no guard
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            res_q <= 10'h000;
        end else if (done_ev) begin
            res_q <= sar_q; // [RL6] [RL7]
        end
    end

    // pin enables and irq mask
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_q  <= 4'h0;
            mask_q <= 2'h0;
        end else if (wr) begin
            if (paddr == `SADC_ADDR_PIN_EN) begin
                pin_q <= pwdata[3:0]; // [RL14]
            end
            if (paddr == `SADC_ADDR_IRQ_MASK) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    // sticky events: bit0 done, bit1 start; read clears, set wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= 2'h0;
        end else begin
            stat_q <= ((rd && paddr == `SADC_ADDR_IRQ_STAT) ? 2'h0 : stat_q)
                      | {start_wr, done_ev};
        end
    end

    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0000_0000;
        case (paddr)
            `SADC_ADDR_CTRL:     rdata_d[7:0] = ctrl_q;
            `SADC_ADDR_RES_HI:   rdata_d[7:0] = res_q[9:2]; // [RL15]
            `SADC_ADDR_RES_LO:   rdata_d[7:6] = res_q[1:0]; // [RL15]
            `SADC_ADDR_IRQ_STAT: rdata_d[1:0] = stat_q;
            `SADC_ADDR_IRQ_MASK: rdata_d[1:0] = mask_q;
            `SADC_ADDR_PIN_EN:   rdata_d[3:0] = pin_q;
            default:             hit = 1'b0;
        endcase
    end

    // no wait state: answer registered in the setup cycle, seen in the access cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rdata_d
                                                     : 32'h0000_0000;
        end
    end

    // analog side outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dac_code      <= 10'h000;
            mux_sel       <= 2'h0;
            analog_pin_en <= 4'h0;
            conv_busy     <= 1'b0;
            irq           <= 1'b0;
        end else begin
            dac_code      <= sar_q;
            mux_sel       <= ctrl_q[`SADC_CTRL_CH_HI:`SADC_CTRL_CH_LO]; // [RL1]
            analog_pin_en <= pin_q; // [RL14]
            conv_busy     <= state_q != sadc_pkg::SADC_IDLE;
            irq           <= |(stat_q & mask_q);
        end
    end
endmodule : sadc_sequencer

/* sadc_asserts.sv */
`timescale 1ns/100ps
`include "sadc_consts.svh"
module sadc_asserts (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [9:0]  dac_code,
    input wire logic [1:0]  mux_sel,
    input wire logic [3:0]  analog_pin_en,
    input wire logic        conv_busy
);
    logic [9:0] bcnt_q;
    logic       cw, pw, um;
    assign cw = psel && penable && pwrite && paddr == `SADC_ADDR_CTRL;
    assign pw = psel && penable && pwrite && paddr == `SADC_ADDR_PIN_EN;
    assign um = paddr < `SADC_ADDR_CTRL || paddr > `SADC_ADDR_PIN_EN
                || paddr[1:0] != 2'h0;
    // saturates so a hung sequencer cannot wrap into the legal window
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) bcnt_q <= 10'h000;
        else if (!conv_busy) bcnt_q <= 10'h000;
        else if (bcnt_q != 10'h3ff) bcnt_q <= bcnt_q + 10'h001;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    bus_answer_a: assert property (setup_s |=> answer_s)
        else $error("pready not one cycle after setup");
    err_only_a: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    unmapped_err_a: assert property (setup_s and um |=> pslverr)
        else $error("unmapped access not refused");
    rdata_idle_a: assert property (!pready |->
        prdata == 32'h0000_0000) else $error("prdata not zero when idle");
    chan_src_a: assert property ($changed(mux_sel) |-> $past(cw) ||
        $past(cw, 2)) else $error("channel moved without write");
    pin_src_a: assert property ($changed(analog_pin_en) |->
        $past(pw) || $past(pw, 2)) else $error("pins moved without write");
    half_scale_a: assert property ($rose(conv_busy) |->
        ##[0:3] dac_code == `SADC_SAR_INIT) else $error("no half scale");
    conv_len_a: assert property ($fell(conv_busy) |->
        bcnt_q >= 10'h060 && bcnt_q <= 10'h33e) else $error("bad length");
    idle_hold_a: assert property (!conv_busy [*3] |->
        $stable(dac_code)) else $error("trial code moves while idle");
endmodule : sadc_asserts
bind sadc_sequencer sadc_asserts u_chk (.core_clk, .nrst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dac_code,
    .mux_sel, .analog_pin_en, .conv_busy);

/* sadc_analog_model.sv */
`timescale 1ns/100ps
module sadc_analog_model (
    input wire logic [9:0] lvl [4],
    input wire logic [9:0] dac_code,
    input wire logic [1:0] mux_sel,
    input wire logic [3:0] analog_pin_en,
    output logic           cmp_above
);
    // input sits half an lsb above its code, so a trial never ties
    assign cmp_above = analog_pin_en[mux_sel] &&
        {lvl[mux_sel], 1'b1} > {dac_code, 1'b0};
endmodule : sadc_analog_model

/* test_sar_adc_sequencer.sv */
`timescale 1ns/100ps
`include "sadc_consts.svh"
module test_sar_adc_sequencer;
    logic        core_clk, nrst, psel, penable, pwrite;
    logic        pready, pslverr, cmp_above, conv_busy, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, c;
    logic [9:0]  dac_code, lvl [4];
    logic [1:0]  mux_sel;
    logic [3:0]  analog_pin_en;
    logic [32:0] expq [$];
    int          err_total, n_compared, cnt;
    sadc_sequencer u_dut (.core_clk, .nrst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_above,
        .dac_code, .mux_sel, .analog_pin_en, .conv_busy, .irq);
    sadc_analog_model u_ana (.lvl, .dac_code, .mux_sel, .analog_pin_en,
        .cmp_above);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [32:0] s, e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back({1'b0, e});
        apb(a, 1'b0, 32'h0000_0000);
    endtask : rd
    task automatic cwait(output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (conv_busy !== 1'b0 && k < 2000);
        if (k >= 2000) begin
            err_total++;
            wrap_up();
        end
    endtask : cwait
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("read", {pslverr, prdata},
                expq.size() > 0 ? expq.pop_front() : 33'hx);
        end
    end
    initial begin
        {nrst, psel, penable, pwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        err_total = 0;
        n_compared = 0;
        foreach (lvl[i]) lvl[i] = 10'h000;
        void'($urandom(32'hc903));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        rd(`SADC_ADDR_CTRL, 32'(`SADC_CTRL_RESET));
        rd(`SADC_ADDR_IRQ_STAT, 32'h0000_0000);
        expq.push_back({1'b1, 32'h0000_0000});
        apb(12'h0f0, 1'b0, 32'h0000_0000);
        apb(`SADC_ADDR_PIN_EN, 1'b1, 32'h0000_000f);
        rd(`SADC_ADDR_PIN_EN, 32'h0000_000f);
        chk("pins", 33'(analog_pin_en), 33'h0000_000f);
        apb(`SADC_ADDR_IRQ_MASK, 1'b1, 32'h0000_0001);
        $display("register map test done");
        for (int i = 0; i < 4; i++) begin
            lvl[i] <= 10'($urandom);
            c = 32'(i) * 32'h0000_0012 + 32'h0000_0001;
            apb(`SADC_ADDR_CTRL, 1'b1, c);
            rd(`SADC_ADDR_CTRL, c);
            chk("mux", 33'(mux_sel), 33'(i));
            cwait(cnt);
            chk("len", 33'(cnt >= (50 << (i + 1)) - 8 &&
                cnt <= (50 << (i + 1)) + 8), 33'h1);
            chk("dac", 33'(dac_code), 33'(lvl[i]));
            rd(`SADC_ADDR_CTRL, c ^ 32'h0000_0009);
            chk("irq", 33'(irq), 33'h1);
            rd(`SADC_ADDR_IRQ_STAT, 32'h0000_0003);
            rd(`SADC_ADDR_RES_HI, 32'(lvl[i][9:2]));
            chk("irq", 33'(irq), 33'h0);
            rd(`SADC_ADDR_RES_LO, {24'h0, lvl[i][1:0], 6'h0});
            $display("conversion %0d test done", i);
        end
        apb(`SADC_ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
        apb(`SADC_ADDR_CTRL, 1'b1, 32'h0000_0001);
        rd(`SADC_ADDR_CTRL, 32'h0000_0001);
        cwait(cnt);
        chk("irq", 33'(irq), 33'h0);
        apb(`SADC_ADDR_IRQ_MASK, 1'b1, 32'h0000_0002);
        rd(`SADC_ADDR_CTRL, 32'h0000_0008);
        chk("irq", 33'(irq), 33'h1);
        apb(`SADC_ADDR_IRQ_MASK, 1'b1, 32'h0000_0001);
        rd(`SADC_ADDR_CTRL, 32'h0000_0008);
        chk("irq", 33'(irq), 33'h1);
        rd(`SADC_ADDR_IRQ_STAT, 32'h0000_0003);
        rd(`SADC_ADDR_CTRL, 32'h0000_0008);
        chk("irq", 33'(irq), 33'h0);
        $display("mask test done");
        wrap_up();
    end
endmodule : test_sar_adc_sequencer
